// ===== rtl/lvds_rx_pkg.sv
// Constants shared by the serial-link-to-LVDS video receiver and its FIFO.
// Assumes every user writes lvds_rx_pkg::name; nothing is imported.
package lvds_rx_pkg;
    // Forward symbol layout, first serial bit in bit 0
    localparam int SYM_W        = 35;
    localparam int PAY_W        = 32;
    localparam int BIT_START    = 0;
    localparam int BIT_INV      = 33;
    localparam int BIT_STOP     = 34;
    localparam int PAY_LSB      = 1;
    localparam logic [5:0] SYM_LAST = 6'h22;

    // Payload fields after descrambling
    localparam int F_RGB        = 0;
    localparam int RGB_W        = 24;
    localparam int F_HS         = 24;
    localparam int F_VS         = 25;
    localparam int F_DE         = 26;
    localparam int F_SCL        = 27;
    localparam int F_SDA        = 28;
    localparam int F_GPIO       = 29;
    localparam int F_AUDIO      = 31;

    // Link and lock
    localparam int SER_LANES    = 2;
    localparam logic [2:0] LOCK_GOOD = 3'h4;
    localparam logic [15:0] SCR_SEED = 16'hace1;

    // Display output
    localparam int LVDS_LANES   = 8;
    localparam int CH_LANES     = 4;
    localparam int SLOT_N       = 7;
    localparam int CH_W         = 28;
    localparam logic [2:0] SLOT_LAST = 3'h6;
    localparam logic [6:0] CLK_PATTERN = 7'h63;
    localparam int LATENCY_PERIODS = 147;

    // Buffering
    localparam int FIFO_DEPTH   = 32;
endpackage

// ===== rtl/pixel_fifo.sv
// Synchronous FIFO for decoded pixels, read data held in a register.
// Assumes one clock; valid/ready handshakes on both sides.
`timescale 1ns/100ps
module pixel_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic [WIDTH-1:0] out_q, out_d;
    logic             ov_q, ov_d;
    logic             wr_en, rd_en;

    always_comb begin
        o_in_ready = (cnt_q != (AW+1)'(DEPTH));
        wr_en      = i_in_valid && o_in_ready;
        rd_en      = (cnt_q != '0) && (!ov_q || i_out_ready);
        wr_d       = wr_q;
        rd_d       = rd_q;
        out_d      = out_q;
        ov_d       = ov_q && !i_out_ready;
        if (wr_en) begin
            wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
        end
        if (rd_en) begin
            rd_d  = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            out_d = mem_q[rd_q];
            ov_d  = 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    end

    always_ff @(posedge i_clk) begin
        if (wr_en) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            out_q <= '0;
            ov_q  <= 1'b0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            ov_q  <= ov_d;
        end
    end

    assign o_out_valid = ov_q;
    assign o_out_data  = out_q;
endmodule

// ===== rtl/lvds_video_rx.sv
// Forward datapath of a serial-link video receiver driving an LVDS display output.
// Assumes link clock and lanes are slow against i_clk and sampled by it.
// Functional notes
// [R01] One 35-bit symbol per pixel, one or two lanes
// [R02] Single 4+1 or dual 8+2 LVDS output
// [R03] Seven bits per lane per output clock
// [R04] Bit 0 first, bit 6 in last slot
// [R05] Fixed 147 output-period latency, input to output; in two-lane mode lane 1 pixels take one period more
// [R06] Pixel clock within single/two-lane limits
// [R07] Lock to any data, no reference or training
// [R08] Decrypt video and audio; only decrypted video out
// [R09] Split symbol into RGB, sync, I2C, GPIO, audio
// [R10] Undo randomizing, balancing and scrambling
// [R11] Bridge I2C across link with arbitration
// [R12] Local host reaches both ends over I2C
// [R13] Lock raised only with valid outputs
// [R14] Dual output alternates pixels between channels
`timescale 1ns/100ps
module lvds_video_rx #(
    parameter int LATENCY = lvds_rx_pkg::LATENCY_PERIODS,
    parameter int DEPTH   = lvds_rx_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Serial link
    input  wire logic        i_link_clk,
    input  wire logic [1:0]  i_link_lane,
    // Configuration
    input  wire logic        i_power_down_n,
    input  wire logic        i_two_lane,
    input  wire logic        i_dual_out,
    input  wire logic        i_hdcp_en,
    input  wire logic [23:0] i_hdcp_key,
    // Local I2C bus
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_scl,
    output logic             o_scl_oe,
    output logic             o_sda,
    output logic             o_sda_oe,
    output logic             o_back_scl,
    output logic             o_back_sda,
    output logic             o_arb_lost,
    // Status and side data
    output logic             o_lock,
    output logic [1:0]       o_gpio,
    output logic             o_audio,
    // LVDS display output
    output logic [7:0]       o_lvds_data,
    output logic             o_lvds_clock_lane_a,
    output logic             o_lvds_clock_lane_b
);
    localparam int NL = lvds_rx_pkg::SER_LANES;

    // Pins cross into i_clk through two flops; only the second is read
    logic [5:0] sy1_q, sy2_q;
    logic       lclk_prev_q;
    logic       rise, pdn;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sy1_q       <= '0;
            sy2_q       <= '0;
            lclk_prev_q <= 1'b0;
        end else begin
            sy1_q       <= {i_sda, i_scl, i_power_down_n, i_link_lane, i_link_clk};
            sy2_q       <= sy1_q;
            lclk_prev_q <= sy2_q[0];
        end
    end

    // Link edges are found by sampling; the pixel rate limits keep them far apart
    assign rise = sy2_q[0] && !lclk_prev_q; // [R06]
    assign pdn  = sy2_q[3];

    function automatic logic [15:0] scr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Per-lane symbol hunt, lock and descrambling
    logic [NL-1:0]       lock, hv, take;
    logic [NL-1:0][31:0] hold;
    logic                lock_all;

    for (genvar l = 0; l < NL; l++) begin : g_lane
        logic [34:0] sr_q, sr_d;
        logic [5:0]  cnt_q, cnt_d;
        logic [2:0]  good_q, good_d;
        logic        lk_q, lk_d, hv_q, hv_d;
        logic [15:0] scr_q, scr_d;
        logic [31:0] hold_q, hold_d;
        logic        act, frame_ok;

        always_comb begin
            act      = (l == 0) || i_two_lane;
            sr_d     = sr_q;
            cnt_d    = cnt_q;
            good_d   = good_q;
            lk_d     = lk_q;
            scr_d    = scr_q;
            hold_d   = hold_q;
            hv_d     = hv_q && !take[l];
            frame_ok = 1'b0;
            if (!pdn || !act) begin
                cnt_d  = '0;
                good_d = '0;
                lk_d   = 1'b0;
                hv_d   = 1'b0;
            end else if (rise) begin
                sr_d = {sy2_q[1+l], sr_q[34:1]}; // [R01]
                if (cnt_q == lvds_rx_pkg::SYM_LAST) begin
                    frame_ok = sr_d[lvds_rx_pkg::BIT_START] && !sr_d[lvds_rx_pkg::BIT_STOP];
                    if (!frame_ok) begin
                        // Slip one bit and test again: any payload locks in time
                        good_d = '0;
                        lk_d   = 1'b0; // [R07]
                    end else begin
                        cnt_d = '0;
                        if (lk_q) begin
                            hold_d = sr_d[lvds_rx_pkg::PAY_LSB +: lvds_rx_pkg::PAY_W]
                                     ^ {32{sr_d[lvds_rx_pkg::BIT_INV]}}
                                     ^ {scr_q, scr_q}; // [R10]
                            scr_d  = scr_step(scr_q);
                            // An unread symbol is overwritten; the FIFO keeps it rare
                            hv_d   = 1'b1;
                        end else if (good_q == lvds_rx_pkg::LOCK_GOOD) begin
                            lk_d  = 1'b1; // [R07]
                            scr_d = lvds_rx_pkg::SCR_SEED;
                        end else begin
                            good_d = good_q + 1'b1;
                        end
                    end
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
        end

        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                sr_q   <= '0;
                cnt_q  <= '0;
                good_q <= '0;
                lk_q   <= 1'b0;
                hv_q   <= 1'b0;
                scr_q  <= lvds_rx_pkg::SCR_SEED;
                hold_q <= '0;
            end else begin
                sr_q   <= sr_d;
                cnt_q  <= cnt_d;
                good_q <= good_d;
                lk_q   <= lk_d;
                hv_q   <= hv_d;
                scr_q  <= scr_d;
                hold_q <= hold_d;
            end
        end

        assign lock[l] = lk_q;
        assign hv[l]   = hv_q;
        assign hold[l] = hold_q;
    end

    assign lock_all = pdn && lock[0] && (lock[1] || !i_two_lane);

    // Merge lanes in order, decrypt, push at most one pixel per output period
    logic        turn_q, turn_d, pushed_q, pushed_d;
    logic [23:0] key_q, key_d;
    logic        sel, push, fifo_in_ready, boundary;
    logic [31:0] pix;

    always_comb begin
        sel    = i_two_lane && turn_q;
        push   = lock_all && hv[sel] && fifo_in_ready && !pushed_q;
        take   = '0;
        take[sel] = push;
        turn_d = i_two_lane ? (turn_q ^ push) : 1'b0;
        key_d  = key_q;
        pix    = hold[sel];
        if (!lock_all) begin
            key_d  = i_hdcp_key;
            turn_d = 1'b0;
        end else if (push && i_hdcp_en) begin
            pix[lvds_rx_pkg::F_RGB +: lvds_rx_pkg::RGB_W] =
                hold[sel][lvds_rx_pkg::F_RGB +: lvds_rx_pkg::RGB_W] ^ key_q; // [R08]
            pix[lvds_rx_pkg::F_AUDIO] = hold[sel][lvds_rx_pkg::F_AUDIO] ^ key_q[0]; // [R08]
            key_d = {key_q[22:0], key_q[23] ^ key_q[22] ^ key_q[21] ^ key_q[16]};
        end
        pushed_d = boundary ? 1'b0 : (pushed_q || push);
    end

    // Output period timing
    logic [2:0]         slot_q, slot_d;
    logic [LATENCY-1:0] tag_q, tag_d;
    logic               pop, fifo_out_valid;
    logic [31:0]        fifo_out;

    assign boundary = (slot_q == lvds_rx_pkg::SLOT_LAST);

    pixel_fifo #(
        .WIDTH (lvds_rx_pkg::PAY_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_in_valid  (push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (pix),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (pop),
        .o_out_data  (fifo_out)
    );

    // A pixel leaves exactly LATENCY periods after the period it entered
    always_comb begin
        slot_d = boundary ? '0 : slot_q + 1'b1; // [R03]
        tag_d  = tag_q;
        if (!lock_all) begin
            tag_d = '0;
        end else if (boundary) begin
            tag_d = {tag_q[LATENCY-2:0], pushed_q || push}; // [R05]
        end
        pop = boundary && tag_q[LATENCY-1] && fifo_out_valid; // [R05]
    end

    // Channel words and lane shifters
    logic [27:0]      cha_q, cha_d, chb_q, chb_d;
    logic             ph_q, ph_d;
    logic [7:0][6:0]  sh_q, sh_d;
    logic [1:0][6:0]  ck_q, ck_d;
    logic [1:0]       gpio_q, gpio_d;
    logic             aud_q, aud_d, rscl_q, rscl_d, rsda_q, rsda_d, arb_q, arb_d;
    logic [27:0]      word;

    always_comb begin
        word = {1'b0, fifo_out[lvds_rx_pkg::F_DE], fifo_out[lvds_rx_pkg::F_VS],
                fifo_out[lvds_rx_pkg::F_HS],
                fifo_out[lvds_rx_pkg::F_RGB +: lvds_rx_pkg::RGB_W]}; // [R09]
        cha_d  = cha_q;
        chb_d  = chb_q;
        ph_d   = i_dual_out ? ph_q : 1'b0;
        gpio_d = gpio_q;
        aud_d  = aud_q;
        rscl_d = rscl_q;
        rsda_d = rsda_q;
        if (!lock_all) begin
            rscl_d = 1'b1;
            rsda_d = 1'b1;
            ph_d   = 1'b0;
        end else if (pop) begin
            gpio_d = fifo_out[lvds_rx_pkg::F_GPIO +: 2]; // [R09]
            aud_d  = fifo_out[lvds_rx_pkg::F_AUDIO];
            rscl_d = fifo_out[lvds_rx_pkg::F_SCL]; // [R11]
            rsda_d = fifo_out[lvds_rx_pkg::F_SDA];
            if (i_dual_out && ph_q) begin
                chb_d = word; // [R14]
            end else begin
                cha_d = word;
            end
            ph_d = i_dual_out && !ph_q; // [R14]
        end
        // Released remote SDA that reads low while SCL is high means another master won
        arb_d = lock_all && rsda_q && rscl_q && !sy2_q[5]; // [R11]
        // Losing lock blanks the lanes at once, not at the end of the period
        for (int i = 0; i < lvds_rx_pkg::LVDS_LANES; i++) begin
            sh_d[i] = {1'b0, sh_q[i][6:1]}; // [R04]
            if (!lock_all) begin
                sh_d[i] = '0; // [R13]
            end else if (boundary) begin
                if (i < lvds_rx_pkg::CH_LANES) begin
                    sh_d[i] = cha_d[(i % 4) * 7 +: 7]; // [R02]
                end else begin
                    sh_d[i] = i_dual_out ? chb_d[(i % 4) * 7 +: 7] : 7'h00; // [R02]
                end
            end
        end
        for (int c = 0; c < 2; c++) begin
            ck_d[c] = {1'b0, ck_q[c][6:1]};
            if (!lock_all) begin
                ck_d[c] = '0; // [R13]
            end else if (boundary) begin
                ck_d[c] = (c == 0 || i_dual_out) ? lvds_rx_pkg::CLK_PATTERN : 7'h00;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            turn_q   <= 1'b0;
            pushed_q <= 1'b0;
            key_q    <= '0;
            slot_q   <= '0;
            tag_q    <= '0;
            cha_q    <= '0;
            chb_q    <= '0;
            ph_q     <= 1'b0;
            sh_q     <= '0;
            ck_q     <= '0;
            gpio_q   <= '0;
            aud_q    <= 1'b0;
            rscl_q   <= 1'b1;
            rsda_q   <= 1'b1;
            arb_q    <= 1'b0;
        end else begin
            turn_q   <= turn_d;
            pushed_q <= pushed_d;
            key_q    <= key_d;
            slot_q   <= slot_d;
            tag_q    <= tag_d;
            cha_q    <= cha_d;
            chb_q    <= chb_d;
            ph_q     <= ph_d;
            sh_q     <= sh_d;
            ck_q     <= ck_d;
            gpio_q   <= gpio_d;
            aud_q    <= aud_d;
            rscl_q   <= rscl_d;
            rsda_q   <= rsda_d;
            arb_q    <= arb_d;
        end
    end

    for (genvar i = 0; i < lvds_rx_pkg::LVDS_LANES; i++) begin : g_out
        assign o_lvds_data[i] = sh_q[i][0]; // [R04]
    end

    // Lock shows from the first period boundary after every active lane locks (lane 0 alone in single-lane mode), as the first output period starts
    logic lock_out_q;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lock_out_q <= 1'b0;
        end else begin
            lock_out_q <= lock_all && (lock_out_q || boundary); // [R13]
        end
    end

    assign o_lock              = lock_out_q;
    assign o_lvds_clock_lane_a = ck_q[0][0];
    assign o_lvds_clock_lane_b = ck_q[1][0];
    assign o_gpio              = gpio_q;
    assign o_audio             = aud_q;
    // Open-drain: enable low drives the wire low
    assign o_scl               = 1'b0;
    assign o_sda               = 1'b0;
    assign o_scl_oe            = rscl_q; // [R11]
    assign o_sda_oe            = rsda_q;
    // Local bus levels return to the far end so a local host reaches it too
    assign o_back_scl          = sy2_q[4]; // [R12]
    assign o_back_sda          = sy2_q[5]; // [R12]
    assign o_arb_lost          = arb_q;
endmodule

// ===== verif/lvds_video_rx_sva.sv
// Checker on the receiver ports: LVDS clock framing, lock and I2C pins.
// Assumes it is bound to lvds_video_rx; one clock domain only.
`timescale 1ns/100ps
module lvds_video_rx_sva (
    input wire logic       i_clk,
    input wire logic       i_resetn,
    input wire logic       i_power_down_n,
    input wire logic       i_dual_out,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_scl,
    input wire logic       o_sda,
    input wire logic       o_back_scl,
    input wire logic       o_back_sda,
    input wire logic       o_lock,
    input wire logic [7:0] o_lvds_data,
    input wire logic       o_lvds_clock_lane_a,
    input wire logic       o_lvds_clock_lane_b
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    sequence s_hi4;
        o_lvds_clock_lane_a [*4];
    endsequence
    sequence s_lo3;
        !o_lvds_clock_lane_a [*3];
    endsequence
    // A lock drop cuts the pattern short on purpose
    property p_shape;
        disable iff (!i_resetn || !o_lock)
        $rose(o_lvds_clock_lane_a) && $past(o_lock) |-> s_hi4 ##1 s_lo3 ##1 o_lvds_clock_lane_a;
    endproperty
    a_clock_lane_shape: assert property (p_shape)
        else $error("clock lane pattern wrong");
    a_lock_at_boundary: assert property ($rose(o_lock) |-> o_lvds_clock_lane_a
        ##1 o_lvds_clock_lane_a ##1 !o_lvds_clock_lane_a) else $error("lock not at period start");
    a_unlocked_quiet: assert property (!o_lock && !$past(o_lock) |-> o_lvds_data == 8'h00
        && !o_lvds_clock_lane_a && !o_lvds_clock_lane_b) else $error("lanes active unlocked");
    a_single_b_quiet: assert property (!i_dual_out [*3] |-> o_lvds_data[7:4] == 4'h0
        && !o_lvds_clock_lane_b) else $error("channel b active in single mode");
    a_dual_clocks_match: assert property (i_dual_out [*3] ##0 o_lock
        |-> o_lvds_clock_lane_b == o_lvds_clock_lane_a) else $error("clock lanes differ");
    a_od_drive_low: assert property (o_scl == 1'h0 && o_sda == 1'h0)
        else $error("open drain data not low");
    a_back_sda_high: assert property (i_sda [*5] |-> o_back_sda)
        else $error("back sda not high");
    a_back_sda_low: assert property (!i_sda [*5] |-> !o_back_sda)
        else $error("back sda not low");
    a_back_scl_high: assert property (i_scl [*5] |-> o_back_scl)
        else $error("back scl not high");
    a_pdn_unlock: assert property ($fell(i_power_down_n) |-> ##[1:8] !o_lock)
        else $error("lock held in power down");
endmodule

bind lvds_video_rx lvds_video_rx_sva chk_u (.i_clk, .i_resetn, .i_power_down_n, .i_dual_out,
    .i_scl, .i_sda, .o_scl, .o_sda, .o_back_scl, .o_back_sda, .o_lock, .o_lvds_data,
    .o_lvds_clock_lane_a, .o_lvds_clock_lane_b);

// ===== verif/ser_model.sv
// Behavioural serializer: frames pixels onto one or two link lanes.
// Assumes the receiver takes lane bits on the link clock rising edge.
`timescale 1ns/100ps
module ser_model (
    output logic       o_link_clk,
    output logic [1:0] o_link_lane
);
    logic [15:0] scr_q [2];
    realtime     done_t [64];
    initial begin
        o_link_clk  = 1'h0;
        o_link_lane = 2'h1;
    end
    function automatic logic [31:0] pix_pay(input int i);
        logic [7:0] b;
        b = 8'(i);
        return {b[0], b[2:1], 1'(i != 5), 1'h1, 1'h1, b[1], b[0], 24'(i + 1) * 24'h010203};
    endfunction
    function automatic logic [34:0] frame(input logic [31:0] p, input logic v, input logic [15:0] s);
        return {1'h0, v, p ^ {32{v}} ^ {s, s}, 1'h1};
    endfunction
    // Link clock stands still after the last symbol of a send; released lanes show the inverse
    task automatic put(input logic [34:0] f0, input logic [34:0] f1, input logic two);
        for (int b = 0; b < 35; b++) begin
            o_link_lane = {two ? f1[b] : ~f0[b], f0[b]};
            #31.2 o_link_clk = 1'h1;
            #62.5 o_link_clk = 1'h0;
            #31.3;
        end
        o_link_lane = ~o_link_lane;
    endtask
    task automatic send(input int ns, input int first, input int np, input logic two,
                        input logic bad);
        logic [34:0] f [2];
        int          n;
        n = two ? 2 : 1;
        for (int k = 0; k < ns; k++) begin
            f[0] = frame(32'(k) * 32'h9e3779b9, 1'(k), 16'h0);
            put(f[0], f[0], two);
        end
        if (ns > 0) begin
            scr_q[0] = lvds_rx_pkg::SCR_SEED;
            scr_q[1] = lvds_rx_pkg::SCR_SEED;
        end
        if (bad) begin
            put(35'h0, 35'h0, two);
        end
        for (int p = 0; p < np; p += n) begin
            for (int l = 0; l < n; l++) begin
                f[l] = frame(pix_pay(first + p + l), 1'(p >> 1), scr_q[l]);
                scr_q[l] = {scr_q[l][14:0],
                            scr_q[l][15] ^ scr_q[l][13] ^ scr_q[l][12] ^ scr_q[l][10]};
            end
            put(f[0], f[1], two);
            for (int l = 0; l < n; l++) begin
                done_t[first + p + l] = $realtime - 93.8;
            end
        end
    endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench: link frames in, LVDS words and I2C levels out.
// Assumes ser_model drives the link and the checker is bound to the design.
`timescale 1ns/100ps
module testbench;
    localparam int LAT = 8;
    logic        i_clk, i_resetn, i_power_down_n, i_two_lane, i_dual_out, i_hdcp_en;
    logic        loc_scl, loc_sda, ck_prev;
    logic [23:0] i_hdcp_key;
    logic        o_scl, o_scl_oe, o_sda, o_sda_oe, o_back_scl, o_back_sda, o_arb_lost;
    logic        o_lock, o_audio, ck_a, ck_b;
    wire logic   i_scl = loc_scl & o_scl_oe;
    wire logic   i_sda = loc_sda & o_sda_oe;
    wire logic   link_clk;
    wire logic [1:0] link_lane;
    logic [1:0]  o_gpio;
    logic [7:0]  o_lvds_data;
    logic [27:0] wa, wb, last_a, last_b, exp_w [64];
    int          err_count = 0;
    int          cmp_count = 0;
    int          slot = 0;
    int          qa[$], qb[$];

    lvds_video_rx #(.LATENCY(LAT), .DEPTH(32)) dut_u (.i_clk, .i_resetn,
        .i_link_clk(link_clk), .i_link_lane(link_lane), .i_power_down_n, .i_two_lane,
        .i_dual_out, .i_hdcp_en, .i_hdcp_key, .i_scl, .i_sda, .o_scl, .o_scl_oe, .o_sda,
        .o_sda_oe, .o_back_scl, .o_back_sda, .o_arb_lost, .o_lock, .o_gpio, .o_audio,
        .o_lvds_data, .o_lvds_clock_lane_a(ck_a), .o_lvds_clock_lane_b(ck_b));
    ser_model ser_u (.o_link_clk(link_clk), .o_link_lane(link_lane));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Idle periods repeat or blank the word, so only changes are compared
    task automatic take(input logic [27:0] w, ref logic [27:0] last, ref int q[$]);
        int i;
        int t;
        if (w === last || w === 28'h0) return;
        last = w;
        if (q.size() == 0) begin
            chk("extra_word", 32'(w), 32'h0);
            return;
        end
        i = q.pop_front();
        t = int'(($realtime - ser_u.done_t[i]) / 4.0);
        chk("lvds_word", 32'(w), 32'(exp_w[i]));
        chk("latency", 32'(t >= (LAT + 2) * 7 - 4 && t <= (LAT + 2) * 7 + 16 + 7 * i_two_lane), 32'h1);
        if (!i_dual_out && !i_hdcp_en) begin
            chk("side", 32'({o_audio, o_gpio}), ser_u.pix_pay(i) >> 29);
        end
    endtask
    always @(negedge i_clk) begin
        // Parked on the last slot while unlocked, so the first locked period starts at 0
        slot = (o_lock !== 1'h1) ? 6 : (ck_a === 1'h0 && ck_prev === 1'h1) ? 2 : (slot + 1) % 7;
        ck_prev = ck_a;
        for (int k = 0; k < 4; k++) begin
            wa[7 * k + slot] = o_lvds_data[k];
            wb[7 * k + slot] = o_lvds_data[k + 4];
        end
        if (slot == 6 && o_lock === 1'h1) begin
            take(wa, last_a, qa);
            take(wb, last_b, qb);
        end
    end
    task automatic expect_pix(input int first, input int n, input logic [23:0] key);
        logic [31:0] p;
        for (int i = first; i < first + n; i++) begin
            p = ser_u.pix_pay(i);
            exp_w[i] = {1'h0, p[26:24], p[23:0] ^ key};
            key = {key[22:0], key[23] ^ key[22] ^ key[21] ^ key[16]};
            if (i_dual_out && (i - first) % 2 == 1) qb.push_back(i);
            else qa.push_back(i);
        end
    endtask
    task automatic drain();
        repeat ((LAT + 4) * 7 + 40) @(posedge i_clk);
        chk("all_seen", 32'(qa.size() + qb.size()), 32'h0);
    endtask
    task automatic power_cycle(input logic two, input logic dual, input logic hd);
        @(posedge i_clk) i_power_down_n <= 1'h0;
        repeat (10) @(posedge i_clk);
        chk("pdn_lock", 32'(o_lock), 32'h0);
        i_two_lane <= two;
        i_dual_out <= dual;
        i_hdcp_en <= hd;
        @(posedge i_clk) i_power_down_n <= 1'h1;
        repeat (10) @(posedge i_clk);
    endtask
    task automatic t_partial_lock();
        ser_u.send(4, 0, 0, 1'h0, 1'h0);
        repeat (50) @(posedge i_clk);
        chk("lock_early", 32'(o_lock), 32'h0);
    endtask
    task automatic t_single_i2c();
        power_cycle(1'h0, 1'h0, 1'h0);
        expect_pix(0, 6, 24'h0);
        ser_u.send(5, 0, 6, 1'h0, 1'h0);
        drain();
        chk("lock_up", 32'(o_lock), 32'h1);
        chk("remote_sda_low", 32'(o_sda_oe), 32'h0);
        expect_pix(6, 1, 24'h0);
        ser_u.send(0, 6, 1, 1'h0, 1'h0);
        drain();
        chk("remote_sda_free", 32'(o_sda_oe), 32'h1);
        @(posedge i_clk) loc_sda <= 1'h0;
        repeat (10) @(posedge i_clk);
        chk("arb_lost", 32'(o_arb_lost), 32'h1);
        @(posedge i_clk) loc_sda <= 1'h1;
        repeat (10) @(posedge i_clk);
        chk("arb_clear", 32'(o_arb_lost), 32'h0);
    endtask
    task automatic t_stream(input logic two, input logic dual, input logic [23:0] key, int first);
        i_hdcp_key <= key;
        power_cycle(two, dual, key != 24'h0);
        expect_pix(first, 8, key);
        ser_u.send(5, first, 8, two, 1'h0);
        drain();
    endtask
    task automatic t_bad_frame();
        ser_u.send(0, 0, 0, 1'h0, 1'h1);
        repeat (30) @(posedge i_clk);
        chk("bad_unlock", 32'(o_lock), 32'h0);
    endtask
    // Two lanes into one channel: every odd pixel waits a period in its lane hold register before the push
    task automatic t_fifo();
        t_stream(1'h1, 1'h0, 24'h0, 32);
        chk("fifo_lock", 32'(o_lock), 32'h1);
        chk("fifo_b_idle", 32'(o_lvds_data[7:4]), 32'h0);
        chk("fifo_count", 32'(qa.size()), 32'h0);
    endtask
    initial begin
        i_clk = 1'h0;
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        {i_resetn, i_two_lane, i_dual_out, i_hdcp_en} = 4'h0;
        {i_power_down_n, loc_scl, loc_sda} = 3'h7;
        {i_hdcp_key, last_a, last_b} = '0;
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'h1;
        repeat (4) @(posedge i_clk);
        t_partial_lock();
        t_single_i2c();
        t_stream(1'h1, 1'h1, 24'h0, 8);
        t_stream(1'h0, 1'h0, 24'h5ac3e1, 16);
        t_stream(1'h0, 1'h1, 24'h0, 24);
        t_bad_frame();
        t_fifo();
        complete_run();
    end
    initial begin
        #400000;
        err_count++;
        complete_run();
    end
endmodule
